//--- logic/iex_params.svh
/*
  timing counts, address prefixes, reset values and sizes for the
  port expander and memory write block; included by the top-level design file only.
*/
`ifndef IEX_PARAMS_SVH
`define IEX_PARAMS_SVH
`define IEX_CLK_MHZ       200
`define IEX_T_PROG_US     5000
`define IEX_PROG_CYCLES   (`IEX_T_PROG_US * `IEX_CLK_MHZ)
`define IEX_PORT_MSB      1'b1
`define IEX_MEM_MSB       1'b0
`define IEX_PORT_RESET    8'hff
`define IEX_PAGE_BYTES    16
`define IEX_MEM_BYTES     256
`endif

//--- logic/iex_pkg.sv
/*
  types shared by the port expander and memory write block.
  assumes nothing of its surroundings.
*/
package iex_pkg;
  typedef logic [7:0] iex_byte_t;
  typedef enum logic [2:0] {
    IEX_IDLE = 3'h0,
    IEX_ADDR = 3'h1,
    IEX_ACK  = 3'h2,
    IEX_RX   = 3'h3,
    IEX_TX   = 3'h4,
    IEX_MACK = 3'h5
  } iex_state_t;
endpackage

//--- logic/iex_buf2.sv
/*
  small fifo with valid and ready on both sides, depth two by default.
  assumes one clock and an active-low asynchronous reset.
*/
`timescale 1ns/1ps
module iex_buf2 #(
  parameter int W = 8,
  parameter int D = 2
) (
  input  wire logic         ref_clk,
  input  wire logic         rstn,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;
  logic [W-1:0] store_q [D];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0]   cnt_q;
  logic          push;
  logic          pop;

  assign in_ready  = (cnt_q != (AW+1)'(D));
  assign out_valid = (cnt_q != '0);
  assign out_data  = store_q[rd_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge ref_clk) begin
    if (push) begin
      store_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(D-1)) ? '0 : wr_q + AW'(1);
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(D-1)) ? '0 : rd_q + AW'(1);
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

//--- logic/iex_top.sv
/*
  two-wire slave with an eight-bit quasi-bidirectional port, a change
  interrupt and a 256-byte memory with byte and page write.
  assumes serial pins, port pins and straps arrive asynchronously and that
  the board resolves each open-drain wire from the enables.
*/
`timescale 1ns/1ps
`include "iex_params.svh"

// Overview of operation
// - port address msb 1, memory msb 0
// - six select pins give low address bits
// - last address bit: 1 read, 0 write
// - one port byte follows address acknowledge
// - write drives pins, read returns levels
// - pins start high with weak pull-up
// - strong pull-up until next clock fall
// - any pin edge asserts change interrupt
// - returning to old value releases interrupt
// - port read clears at ack rise
// - port write clears at clock fall before ack
// - changes during ack pulse may vanish
// - later changes assert again after clearing
// - other slaves leave interrupt untouched
// - memory write carries eight-bit word address
// - protect pin high blocks memory writes
// - acknowledge address, word address, data
// - stop starts timed programming cycle
// - port served while programming, memory not
// - page data increments low four bits
// - more than sixteen bytes wrap page
module iex_top
  import iex_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = `IEX_PROG_CYCLES
) (
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_n,
  input  wire logic [5:0] addr_select_pins,
  input  wire logic       mem_write_protect_n,
  input  wire logic [3:0] port_pins_low_i,
  input  wire logic [3:0] port_pins_high_i,
  output logic [3:0]      port_pins_low_o,
  output logic [3:0]      port_pins_high_o,
  output logic [3:0]      port_pins_low_oe_n,
  output logic [3:0]      port_pins_high_oe_n,
  output logic [3:0]      port_pullup_low,
  output logic [3:0]      port_pullup_high,
  output logic            irq_o,
  output logic            irq_oe_n
);
  logic [2:0]  scl_q;
  logic [2:0]  sda_q;
  iex_byte_t   pin_s1_q;
  iex_byte_t   pin_s2_q;
  logic [5:0]  adr_s1_q;
  logic [5:0]  adr_s2_q;
  logic        wp_s1_q;
  logic        wp_s2_q;
  iex_state_t  state_q;
  logic [3:0]  bit_q;
  iex_byte_t   sh_q;
  logic        sel_port_q;
  logic        rd_q;
  logic        wadr_q;
  logic        ack_seen_q;
  logic        sda_oe_n_q;
  logic        zero_q;
  iex_byte_t   port_q;
  iex_byte_t   pu_q;
  iex_byte_t   ref_q;
  logic        irq_oe_n_q;
  iex_byte_t   mem_q [`IEX_MEM_BYTES];
  iex_byte_t   page_q [`IEX_PAGE_BYTES];
  logic [15:0] pmask_q;
  logic [3:0]  base_q;
  logic [3:0]  wptr_q;
  iex_byte_t   cur_addr_q;
  logic        busy_q;
  logic [31:0] prog_cnt_q;
  logic        scl_rise;
  logic        scl_fall;
  logic        start_ev;
  logic        stop_ev;
  logic        byte_done;
  logic        addr_port;
  logic        addr_mem;
  logic        ack_d;
  logic        port_wr;
  logic        waddr_set;
  logic        data_push;
  logic        tx_load;
  logic        irq_clr;
  logic        commit;
  logic        buf_in_ready;
  logic        buf_out_valid;
  iex_byte_t   buf_out_data;
  iex_byte_t   tx_byte;

  // two flops before use; the third stage only feeds edge detection
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      scl_q    <= 3'h7;
      sda_q    <= 3'h7;
      pin_s1_q <= 8'hff;
      pin_s2_q <= 8'hff;
      adr_s1_q <= 6'h3f;
      adr_s2_q <= 6'h3f;
      wp_s1_q  <= 1'h1;
      wp_s2_q  <= 1'h1;
    end else begin
      scl_q    <= {scl_q[1:0], scl_i};
      sda_q    <= {sda_q[1:0], sda_i};
      pin_s1_q <= {port_pins_high_i, port_pins_low_i};
      pin_s2_q <= pin_s1_q;
      adr_s1_q <= addr_select_pins;
      adr_s2_q <= adr_s1_q;
      wp_s1_q  <= mem_write_protect_n;
      wp_s2_q  <= wp_s1_q;
    end
  end

  assign scl_rise  = scl_q[1] && !scl_q[2];
  assign scl_fall  = !scl_q[1] && scl_q[2];
  assign start_ev  = scl_q[1] && scl_q[2] && sda_q[2] && !sda_q[1];
  assign stop_ev   = scl_q[1] && scl_q[2] && !sda_q[2] && sda_q[1];
  assign byte_done = scl_fall && (bit_q == 4'h8)
                     && (state_q == IEX_ADDR || state_q == IEX_RX);
  assign addr_port = (sh_q[7:1] == {`IEX_PORT_MSB, adr_s2_q});
  assign addr_mem  = (sh_q[7:1] == {`IEX_MEM_MSB, adr_s2_q});
  assign port_wr   = byte_done && state_q == IEX_RX && sel_port_q;
  assign waddr_set = byte_done && state_q == IEX_RX && !sel_port_q && !wadr_q;
  assign data_push = byte_done && state_q == IEX_RX && !sel_port_q && wadr_q;
  assign tx_load   = scl_fall && ((state_q == IEX_ACK && rd_q)
                     || (state_q == IEX_MACK && ack_seen_q));
  assign tx_byte   = sel_port_q ? pin_s2_q : mem_q[cur_addr_q];
  // port clears only for this port's own traffic
  assign irq_clr   = port_wr
                     || (state_q == IEX_ACK && rd_q && sel_port_q && scl_rise);
  assign commit    = stop_ev && (pmask_q != 16'h0) && !busy_q && !wp_s2_q;
  // a full buffer refuses rather than drops
  assign ack_d     = (state_q == IEX_ADDR)
                     ? (addr_port || (addr_mem && !busy_q))
                     : (sel_port_q || !wadr_q || buf_in_ready);

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_q    <= IEX_IDLE;
      bit_q      <= 4'h0;
      sh_q       <= 8'h00;
      sel_port_q <= 1'b0;
      rd_q       <= 1'b0;
      wadr_q     <= 1'b0;
      ack_seen_q <= 1'b0;
      sda_oe_n_q <= 1'b1;
    end else if (start_ev) begin
      state_q    <= IEX_ADDR;
      bit_q      <= 4'h0;
      wadr_q     <= 1'b0;
      sda_oe_n_q <= 1'b1;
    end else if (stop_ev) begin
      state_q    <= IEX_IDLE;
      sda_oe_n_q <= 1'b1;
    end else begin
      case (state_q)
        IEX_ADDR, IEX_RX: begin
          if (scl_rise) begin
            sh_q  <= {sh_q[6:0], sda_q[1]};
            bit_q <= bit_q + 4'h1;
          end else if (byte_done) begin
            state_q    <= ack_d ? IEX_ACK : IEX_IDLE;
            sda_oe_n_q <= !ack_d;
            if (state_q == IEX_ADDR) begin
              sel_port_q <= addr_port;
              rd_q       <= sh_q[0];
            end else if (!sel_port_q) begin
              wadr_q <= 1'b1;
            end
          end
        end
        IEX_ACK: begin
          if (scl_fall) begin
            bit_q <= 4'h0;
            if (rd_q) begin
              state_q    <= IEX_TX;
              sh_q       <= tx_byte;
              sda_oe_n_q <= tx_byte[7];
            end else begin
              state_q    <= IEX_RX;
              sda_oe_n_q <= 1'b1;
            end
          end
        end
        IEX_TX: begin
          if (scl_fall) begin
            if (bit_q == 4'h7) begin
              state_q    <= IEX_MACK;
              sda_oe_n_q <= 1'b1;
            end else begin
              sh_q       <= {sh_q[6:0], 1'b0};
              sda_oe_n_q <= sh_q[6];
              bit_q      <= bit_q + 4'h1;
            end
          end
        end
        IEX_MACK: begin
          if (scl_rise) begin
            ack_seen_q <= !sda_q[1];
          end else if (tx_load) begin
            state_q    <= IEX_TX;
            bit_q      <= 4'h0;
            sh_q       <= tx_byte;
            sda_oe_n_q <= tx_byte[7];
          end else if (scl_fall) begin
            state_q <= IEX_IDLE;
          end
        end
        default: begin
          state_q <= IEX_IDLE;
        end
      endcase
    end
  end

  // port latch: a zero bit sinks the pin, a one gets the strong pull-up until the next clock fall, then the weak source
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      port_q <= `IEX_PORT_RESET;
      pu_q   <= 8'h00;
      zero_q <= 1'b0;
    end else if (port_wr) begin
      port_q <= sh_q;
      pu_q   <= sh_q;
    end else if (scl_fall) begin
      pu_q <= 8'h00;
    end
  end

  // compare to the last read or written value; equal again means released
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ref_q      <= `IEX_PORT_RESET;
      irq_oe_n_q <= 1'b1;
    end else if (irq_clr) begin
      ref_q      <= port_wr ? sh_q : pin_s2_q;
      irq_oe_n_q <= 1'b1;
    end else begin
      irq_oe_n_q <= (pin_s2_q == ref_q);
    end
  end

  iex_buf2 #(
    .W (8),
    .D (2)
  ) u_buf (
    .ref_clk   (ref_clk),
    .rstn      (rstn),
    .in_valid  (data_push),
    .in_ready  (buf_in_ready),
    .in_data   (sh_q),
    .out_valid (buf_out_valid),
    .out_ready (!busy_q),
    .out_data  (buf_out_data)
  );

  generate
    for (genvar gi = 0; gi < `IEX_PAGE_BYTES; gi++) begin : g_page
      always_ff @(posedge ref_clk) begin
        if (buf_out_valid && !busy_q && wptr_q == 4'(gi)) begin
          page_q[gi] <= buf_out_data;
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      base_q     <= 4'h0;
      wptr_q     <= 4'h0;
      pmask_q    <= 16'h0000;
      cur_addr_q <= 8'h00;
    end else if (waddr_set) begin
      base_q     <= sh_q[7:4];
      wptr_q     <= sh_q[3:0];
      pmask_q    <= 16'h0000;
      cur_addr_q <= sh_q;
    end else if (buf_out_valid && !busy_q) begin
      pmask_q[wptr_q] <= 1'b1;
      wptr_q          <= wptr_q + 4'h1;
    end else if (stop_ev) begin
      pmask_q <= 16'h0000;
    end else if (tx_load && !sel_port_q) begin
      cur_addr_q <= cur_addr_q + 8'h01;
    end
  end

  // every received page byte lands at stop unless the protect pin is high; the timer then only models the busy window
  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < `IEX_PAGE_BYTES; i++) begin
      if (commit && pmask_q[i]) begin
        mem_q[{base_q, 4'(i)}] <= page_q[i];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      busy_q     <= 1'b0;
      prog_cnt_q <= 32'h0;
    end else if (commit) begin
      busy_q     <= 1'b1;
      prog_cnt_q <= 32'(PROG_CYCLES - 1);
    end else if (busy_q) begin
      prog_cnt_q <= prog_cnt_q - 32'h1;
      busy_q     <= (prog_cnt_q != 32'h0);
    end
  end

  assign sda_o               = zero_q;
  assign sda_oe_n            = sda_oe_n_q;
  assign port_pins_low_o     = {4{zero_q}};
  assign port_pins_high_o    = {4{zero_q}};
  assign port_pins_low_oe_n  = port_q[3:0];
  assign port_pins_high_oe_n = port_q[7:4];
  assign port_pullup_low     = pu_q[3:0];
  assign port_pullup_high    = pu_q[7:4];
  assign irq_o               = zero_q;
  assign irq_oe_n            = irq_oe_n_q;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  logic [31:0] busy_len_q;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      busy_len_q <= 32'h0;
    end else begin
      busy_len_q <= busy_q ? busy_len_q + 32'h1 : 32'h0;
    end
  end
  a_port_ack_addr: assert property (byte_done && state_q == IEX_ADDR && addr_port
    |=> !sda_oe_n_q && state_q == IEX_ACK) else $error("port address not acknowledged");
  a_busy_mem_nack: assert property (byte_done && state_q == IEX_ADDR && addr_mem && busy_q
    |=> sda_oe_n_q && state_q == IEX_IDLE) else $error("busy memory acknowledged");
  a_port_write_drive: assert property (port_wr
    |=> port_pins_low_oe_n == $past(sh_q[3:0]) && port_pins_high_oe_n == $past(sh_q[7:4]))
    else $error("port pins not driven from written byte");
  a_pullup_one_fall: assert property (scl_fall && !port_wr |=> pu_q == 8'h00)
    else $error("strong pull-up outlived clock fall");
  a_irq_assert: assert property ((pin_s2_q != ref_q) && !irq_clr
    |=> !irq_oe_n) else $error("change not flagged");
  a_irq_release: assert property ((pin_s2_q == ref_q) && $stable(ref_q)
    |=> irq_oe_n) else $error("interrupt not released");
  a_other_no_clear: assert property (irq_clr |-> sel_port_q || port_wr
    ) else $error("interrupt cleared by other slave");
  a_protect_holds: assert property (stop_ev && wp_s2_q && !busy_q |=> !busy_q)
    else $error("memory written while protected");
  a_prog_length: assert property ($fell(busy_q) |-> busy_len_q == PROG_CYCLES)
    else $error("programming cycle wrong length");
  a_page_wrap: assert property (buf_out_valid && !busy_q && !waddr_set
    |=> wptr_q == $past(wptr_q) + 4'h1) else $error("page pointer did not advance");
  c_port_read: cover property (state_q == IEX_ACK && rd_q && sel_port_q && scl_rise);
  c_page_wrap: cover property (buf_out_valid && !busy_q && wptr_q == 4'hf);
  c_prog_start: cover property (commit);
  c_irq_seen: cover property ($fell(irq_oe_n));
endmodule

//--- test/iex_master.sv
/*
  behavioural two-wire bus master: start, stop, byte write and byte read.
  assumes the bench resolves the data wire with its pull-up and feeds it back.
*/
`timescale 1ns/1ps
module iex_master (
  input  wire logic ref_clk,
  input  wire logic sda_w,
  output logic      scl,
  output logic      sda_d
);
  // clock idles high between frames; low 12 and high 13 cycles give 125 ns
  initial begin
    scl = 1'b1;
    sda_d = 1'b1;
  end
  task automatic q(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  // also serves as a repeated start from a low clock
  task automatic start();
    q(6);
    sda_d = 1'b1;
    q(6);
    scl = 1'b1;
    q(6);
    sda_d = 1'b0;
    q(6);
    scl = 1'b0;
  endtask
  task automatic stop();
    q(6);
    sda_d = 1'b0;
    q(6);
    scl = 1'b1;
    q(6);
    sda_d = 1'b1;
    q(6);
  endtask
  // data moves mid-low so it never changes while the clock is high
  task automatic bit_io(input logic b, output logic r);
    q(6);
    sda_d = b;
    q(6);
    scl = 1'b1;
    q(6);
    r = sda_w;
    q(7);
    scl = 1'b0;
  endtask
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], r);
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(last, r);
  endtask
endmodule

//--- test/testbench.sv
/*
  self-checking bench for the port expander and memory write block.
  assumes pull-ups on the data wire, the interrupt line and the port pins.
*/
`timescale 1ns/1ps
module testbench;
  import iex_pkg::*;
  // long enough that the busy probe and a port write both fall inside it
  localparam int PROG = 1000;
  localparam logic [5:0] SEL = 6'h2a;
  localparam iex_byte_t PA = {1'b1, SEL, 1'b0};
  localparam iex_byte_t MA = {1'b0, SEL, 1'b0};
  logic       ref_clk = 1'b0;
  logic       rstn = 1'b0;
  logic       wp_n = 1'b0;
  logic       scl, sda_d, sda_o, sda_oe_n, irq_o, irq_oe_n, ack;
  logic [3:0] pl_o, ph_o, pl_oe_n, ph_oe_n, pu_l, pu_h;
  iex_byte_t  ext = 8'hff;
  iex_byte_t  pins, d;
  iex_byte_t  pu_seen = 8'h00;
  int         fail_count = 0;
  int         compares = 0;
  int         cyc = 0;
  wire logic  sda_w = sda_d & (sda_oe_n ? 1'b1 : sda_o);
  assign pins = ext & {ph_oe_n, pl_oe_n};

  always #2.5 ref_clk = ~ref_clk;

  // the strong pull-up lasts only the ack bit, so keep what it showed
  always @(negedge ref_clk) begin
    if ({pu_h, pu_l} != 8'h00) begin
      pu_seen <= {pu_h, pu_l};
    end
  end

  iex_master m_u (.ref_clk(ref_clk), .sda_w(sda_w), .scl(scl), .sda_d(sda_d));

  iex_top #(.PROG_CYCLES(PROG)) dut_u (
    .ref_clk(ref_clk), .rstn(rstn), .scl_i(scl), .sda_i(sda_w),
    .sda_o(sda_o), .sda_oe_n(sda_oe_n), .addr_select_pins(SEL),
    .mem_write_protect_n(wp_n), .port_pins_low_i(pins[3:0]),
    .port_pins_high_i(pins[7:4]), .port_pins_low_o(pl_o), .port_pins_high_o(ph_o),
    .port_pins_low_oe_n(pl_oe_n), .port_pins_high_oe_n(ph_oe_n),
    .port_pullup_low(pu_l), .port_pullup_high(pu_h), .irq_o(irq_o), .irq_oe_n(irq_oe_n)
  );

  task automatic chk(input string n, input iex_byte_t seen, input iex_byte_t exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic complete_run();
    if (fail_count == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic wr2(input iex_byte_t a, input iex_byte_t b);
    m_u.start();
    m_u.wr_byte(a, ack);
    chk("addr_ack", {7'h0, ack}, 8'h01);
    m_u.wr_byte(b, ack);
    chk("data_ack", {7'h0, ack}, 8'h01);
    m_u.stop();
  endtask
  // data bytes are base, base+1, ... so a wrapped page is easy to predict
  task automatic mwr(input iex_byte_t w, input int n, input iex_byte_t base);
    m_u.start();
    m_u.wr_byte(MA, ack);
    chk("mem_addr_ack", {7'h0, ack}, 8'h01);
    m_u.wr_byte(w, ack);
    chk("word_ack", {7'h0, ack}, 8'h01);
    for (int i = 0; i < n; i++) begin
      m_u.wr_byte(base + iex_byte_t'(i), ack);
      chk("mem_data_ack", {7'h0, ack}, 8'h01);
    end
    m_u.stop();
  endtask
  task automatic mem_rd(input iex_byte_t w, input iex_byte_t exp);
    m_u.start();
    m_u.wr_byte(MA, ack);
    m_u.wr_byte(w, ack);
    m_u.start();
    m_u.wr_byte(MA | 8'h01, ack);
    m_u.rd_byte(1'b1, d);
    m_u.stop();
    chk("mem_byte", d, exp);
  endtask
  task automatic irq_is(input logic v);
    repeat (10) @(negedge ref_clk);
    chk("irq", {7'h0, irq_oe_n}, {7'h0, v});
  endtask

  // hang guard, generous against the roughly 15000 cycles the tests use
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fail_count++;
      complete_run();
    end
  end

  initial begin
    repeat (10) @(negedge ref_clk);
    rstn = 1'b1;
    repeat (6) @(negedge ref_clk);
    chk("oe_reset", {ph_oe_n, pl_oe_n}, 8'hff);
    chk("pu_reset", {pu_h, pu_l}, 8'h00);
    chk("irq_reset", {7'h0, irq_oe_n}, 8'h01);
    chk("pin_lvl", {ph_o, pl_o}, 8'h00);
    chk("od_lvl", {6'h0, irq_o, sda_o}, 8'h00);
    m_u.start();
    m_u.wr_byte({1'b1, ~SEL, 1'b0}, ack);
    m_u.stop();
    chk("foreign_nack", {7'h0, ack}, 8'h00);
    // bit 1 is written high before it is used as an input
    wr2(PA, 8'h5a);
    chk("pins", pins, 8'h5a);
    chk("pu_on", pu_seen, 8'h5a);
    ext = 8'hfd;
    irq_is(1'b0);
    ext = 8'hff;
    irq_is(1'b1);
    ext = 8'hfd;
    irq_is(1'b0);
    m_u.start();
    chk("pu_off", {pu_h, pu_l}, 8'h00);
    m_u.wr_byte(PA | 8'h01, ack);
    chk("rd_ack", {7'h0, ack}, 8'h01);
    m_u.rd_byte(1'b1, d);
    m_u.stop();
    chk("port_rd", d, 8'h58);
    irq_is(1'b1);
    ext = 8'hff;
    irq_is(1'b0);
    mwr(8'h10, 1, 8'h3c);
    irq_is(1'b0);
    m_u.start();
    m_u.wr_byte(MA, ack);
    m_u.stop();
    chk("busy_nack", {7'h0, ack}, 8'h00);
    wr2(PA, 8'hff);
    irq_is(1'b1);
    repeat (PROG + 20) @(negedge ref_clk);
    mem_rd(8'h10, 8'h3c);
    repeat (PROG + 20) @(negedge ref_clk);
    // seventeen bytes from 1e: e, f, 0 .. d, then e again
    mwr(8'h1e, 17, 8'h01);
    repeat (PROG + 20) @(negedge ref_clk);
    mem_rd(8'h1e, 8'h11);
    mem_rd(8'h10, 8'h03);
    wp_n = 1'b1;
    mwr(8'h10, 1, 8'h99);
    m_u.start();
    m_u.wr_byte(MA, ack);
    m_u.stop();
    chk("no_busy", {7'h0, ack}, 8'h01);
    mem_rd(8'h10, 8'h03);
    complete_run();
  end
endmodule
